//--- common/cjd_defs.svh
`ifndef CJD_DEFS_SVH
`define CJD_DEFS_SVH

// ----------------------------------------------------------------------
// instruction encodings and operand fields
// ----------------------------------------------------------------------
`define CJD_JARF_HI      7'h1D   // bits 15:9 of jump far on alu flag
`define CJD_JARF_LO      4'h5    // bits 3:0 of jump far on alu flag
`define CJD_JARR_HI      7'h12   // bits 15:9 of jump relative on alu flag
`define CJD_JCRF_HI      6'h0F   // bits 15:10 of jump far on control bit
`define CJD_JCRF_LO      4'h4    // bits 3:0 of jump far on control bit
`define CJD_SEL_MSB      8       // condition / control bit select field
`define CJD_SEL_LSB      5
`define CJD_JREG_BIT     4       // jump register select
`define CJD_POL_BIT      9       // polarity of the control bit test
`define CJD_OFS_MSB      4       // signed relative offset
`define CJD_OFS_W        5

// ----------------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define CJD_IDX_CW_A_B1  10'h101
`define CJD_IDX_CW_B_B1  10'h102
`define CJD_IDX_CW_A_B2  10'h121
`define CJD_IDX_CW_B_B2  10'h122
`define CJD_IDX_JREG0    10'h140
`define CJD_IDX_JREG1    10'h141
`define CJD_IDX_CORE_SEL 10'h142
`define CJD_IDX_STATUS   10'h143

// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define CJD_RST_CW       16'h0000
`define CJD_RST_JREG     16'h0000
`define CJD_RST_CORE_SEL 2'h0
`define CJD_RESP_OKAY    2'h0
`define CJD_RESP_SLVERR  2'h2
`define CJD_TAKEN_BIT    15      // status: last jump was taken

`endif

//--- common/cjd_pkg.sv
package cjd_pkg;
  // ----------------------------------------------------------------------
  // kind of instruction seen on the fetch port
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CJD_OTHER,                        // not a jump handled here
    CJD_JUMP_FAR_ALU,                 // absolute, alu flag condition
    CJD_JUMP_REL_ALU,                 // relative, alu flag condition
    CJD_JUMP_FAR_CTRL                 // absolute, control bit condition
  } cjd_kind_t;
endpackage

//--- logic/cjd_cond_sel.sv
`include "cjd_defs.svh"

// condition selection: one flag out of the alu condition word and one bit
// out of the control word, the latter compared against the polarity
module cjd_cond_sel (
  input  wire logic [15:0] alu_flags_i,     // alu condition register
  input  wire logic [15:0] ctrl_word_i,     // this core's control word
  input  wire logic [3:0]  alu_flag_select_i,
  input  wire logic [3:0]  ctrl_bit_index_i,
  input  wire logic        polarity_i,
  output logic             alu_hit_o,       // selected alu flag is set
  output logic             ctrl_hit_o       // control bit matches polarity
);
  // ----------------------------------------------------------------------
  // flag pick
  // ----------------------------------------------------------------------
  // codes 0..15 map one to one onto flag bits: operation complete, signed
  // overflow, signed underflow, unsigned overflow, unsigned underflow,
  // sign, zero, multiply loss, multiply overflow, mask_all_ones,
  // mask_all_zeros, a0, a1, carry, conversion sign, shift carry
  always_comb begin
    alu_hit_o = alu_flags_i[alu_flag_select_i]; // [RULE_05] [RULE_06] [RULE_07] [RULE_08] [RULE_09]
  end

  // ----------------------------------------------------------------------
  // control bit pick
  // ----------------------------------------------------------------------
  // index n selects bit n, 0 is the lsb; polarity 1 tests for a one
  always_comb begin
    ctrl_hit_o = (ctrl_word_i[ctrl_bit_index_i] == polarity_i); // [RULE_12] [RULE_13]
  end
endmodule

//--- logic/cjd_top.sv
// Local design decision: the AXI4-Lite interface to the registers.
`include "cjd_defs.svh"

// Summary of operation
// (RULE_01) far alu jump loads pc from jump register
// (RULE_02) far target comes from selected jump register
// (RULE_03) relative target is instruction address plus offset
// (RULE_04) offset is 5-bit two's complement, -16..15
// (RULE_05) select 0..2: complete, signed over/underflow
// (RULE_06) select 3..5: unsigned over/underflow, sign
// (RULE_07) select 6..8: zero, mult loss, mult overflow
// (RULE_08) select 9..10: mask all ones, all zeros
// (RULE_09) select 11..15: a0, a1, carry, conv, shift
// (RULE_10) conditions come from alu condition register
// (RULE_11) far control jump loads pc on bit match
// (RULE_12) control index n picks control word bit n
// (RULE_13) polarity 0 tests zero, 1 tests one
// (RULE_14) far alu jump decoded from 15:9 and 3:0
// (RULE_15) relative alu jump decoded from bits 15:9
// (RULE_16) far control jump decoded from 15:10, 3:0
// (RULE_17) failed condition advances pc sequentially
// (RULE_18) relative add wraps at code address width
module cjd_top #(
  parameter int ADDR_W = 10          // code memory address width
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // instruction fetch side
  input  wire logic              instr_valid_i,   // one instruction executes
  input  wire logic [15:0]       instr_i,         // word at program_counter_o
  input  wire logic [15:0]       alu_flags_i,     // alu condition register
  output logic      [ADDR_W-1:0] program_counter_o,
  output logic                   jump_taken_o,    // pulse: last instr jumped
  output logic                   jump_seen_o,     // pulse: last instr was a jump
  // axi4-lite register slave
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  // the offset must fit the address, and the pc must stay below the status taken bit 15
  if (ADDR_W < `CJD_OFS_W || ADDR_W > 15) begin : g_bad_width
    $error("cjd_top: ADDR_W must lie between 5 and 15");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0]       ctrl_word_q [4];  // control words, two cores by two banks
  logic [15:0]       jump_reg_q  [2];  // jump_register_set
  logic [1:0]        core_sel_q;       // which control word this core tests
  logic [ADDR_W-1:0] pc_q;             // program_counter
  logic [ADDR_W-1:0] pc_d;
  logic              taken_q;          // last jump was taken (status)
  logic              taken_d;
  logic              jump_seen_q;
  logic              jump_taken_q;

  // write channel holding state
  logic              aw_full_q;
  logic [9:0]        aw_idx_q;
  logic              w_full_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  // read channel state
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // ----------------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------------
  cjd_pkg::cjd_kind_t kind;
  logic [3:0]         alu_flag_select;
  logic [3:0]         ctrl_bit_index;
  logic               jump_register_select;
  logic               polarity;
  logic [`CJD_OFS_W-1:0] offset;
  logic               alu_hit;
  logic               ctrl_hit;
  logic [ADDR_W-1:0]  far_target;
  logic [ADDR_W-1:0]  rel_target;
  logic [ADDR_W-1:0]  seq_target;

  // operand fields sit at fixed positions in every form
  assign alu_flag_select      = instr_i[`CJD_SEL_MSB:`CJD_SEL_LSB];
  assign ctrl_bit_index       = instr_i[`CJD_SEL_MSB:`CJD_SEL_LSB];
  assign jump_register_select = instr_i[`CJD_JREG_BIT];
  assign polarity             = instr_i[`CJD_POL_BIT];
  assign offset               = instr_i[`CJD_OFS_MSB:0];

  // opcode match; the three patterns cannot overlap
  always_comb begin
    kind = cjd_pkg::CJD_OTHER;
    if (instr_i[15:9] == `CJD_JARF_HI && instr_i[3:0] == `CJD_JARF_LO) begin
      kind = cjd_pkg::CJD_JUMP_FAR_ALU; // [RULE_14]
    end else if (instr_i[15:9] == `CJD_JARR_HI) begin
      kind = cjd_pkg::CJD_JUMP_REL_ALU; // [RULE_15]
    end else if (instr_i[15:10] == `CJD_JCRF_HI && instr_i[3:0] == `CJD_JCRF_LO) begin
      kind = cjd_pkg::CJD_JUMP_FAR_CTRL; // [RULE_16]
    end
  end

  // flags come straight from the alu condition register, same clock
  cjd_cond_sel u_cond_sel (
    .alu_flags_i       (alu_flags_i), // [RULE_10]
    .ctrl_word_i       (ctrl_word_q[core_sel_q]),
    .alu_flag_select_i (alu_flag_select),
    .ctrl_bit_index_i  (ctrl_bit_index),
    .polarity_i        (polarity),
    .alu_hit_o         (alu_hit),
    .ctrl_hit_o        (ctrl_hit)
  );

  // ----------------------------------------------------------------------
  // jump targets
  // ----------------------------------------------------------------------
  // any code location is reachable through a jump register
  assign far_target = jump_reg_q[jump_register_select][ADDR_W-1:0]; // [RULE_02]
  // offset sign-extended, add wraps at the code address width
  assign rel_target = pc_q + {{(ADDR_W-`CJD_OFS_W){offset[`CJD_OFS_MSB]}}, offset}; // [RULE_03] [RULE_04] [RULE_18]
  assign seq_target = pc_q + ADDR_W'(1);

  // next program counter for the instruction now at pc_q
  always_comb begin
    pc_d    = seq_target; // [RULE_17]
    taken_d = 1'b0;
    unique case (kind)
      cjd_pkg::CJD_JUMP_FAR_ALU: begin
        if (alu_hit) begin
          pc_d    = far_target; // [RULE_01]
          taken_d = 1'b1;
        end
      end
      cjd_pkg::CJD_JUMP_REL_ALU: begin
        if (alu_hit) begin
          pc_d    = rel_target; // [RULE_03]
          taken_d = 1'b1;
        end
      end
      cjd_pkg::CJD_JUMP_FAR_CTRL: begin
        if (ctrl_hit) begin
          pc_d    = far_target; // [RULE_11]
          taken_d = 1'b1;
        end
      end
      cjd_pkg::CJD_OTHER: begin
        // other instructions are executed elsewhere; pc just advances
        pc_d    = seq_target;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------------
  // pc only moves when an instruction really executes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pc_q <= '0;
    end else if (instr_valid_i) begin
      pc_q <= pc_d;
    end
  end

  // last-jump status, kept until the next jump instruction
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      taken_q <= 1'b0;
    end else if (instr_valid_i && kind != cjd_pkg::CJD_OTHER) begin
      taken_q <= taken_d;
    end
  end

  // one-cycle pulses describing the instruction just executed
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      jump_seen_q  <= 1'b0;
      jump_taken_q <= 1'b0;
    end else begin
      jump_seen_q  <= instr_valid_i && (kind != cjd_pkg::CJD_OTHER);
      jump_taken_q <= instr_valid_i && taken_d;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic commit;
  logic aw_full_nx;
  logic w_full_nx;
  logic bvalid_nx;
  logic w_hit;

  assign aw_take    = s_axi_awvalid && awready_q;
  assign w_take     = s_axi_wvalid && wready_q;
  // address and data may arrive in either order; write once both are held
  assign commit     = aw_full_q && w_full_q && !bvalid_q;
  assign aw_full_nx = (aw_full_q || aw_take) && !commit;
  assign w_full_nx  = (w_full_q || w_take) && !commit;
  assign bvalid_nx  = (bvalid_q && !s_axi_bready) || commit;

  // the decoded index is one of the mapped registers
  always_comb begin
    unique case (aw_idx_q)
      `CJD_IDX_CW_A_B1, `CJD_IDX_CW_B_B1, `CJD_IDX_CW_A_B2, `CJD_IDX_CW_B_B2,
      `CJD_IDX_JREG0, `CJD_IDX_JREG1, `CJD_IDX_CORE_SEL, `CJD_IDX_STATUS:
        w_hit = 1'b1;
      default: w_hit = 1'b0;
    endcase
  end

  // byte-lane merge over the low half word, upper lanes ignored
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0]  = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  // channel holding registers; ready drops while a word is held
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_idx_q  <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      aw_full_q <= aw_full_nx;
      w_full_q  <= w_full_nx;
      awready_q <= !aw_full_nx && !bvalid_nx;
      wready_q  <= !w_full_nx && !bvalid_nx;
      if (aw_take) aw_idx_q <= s_axi_awaddr[11:2];
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // write response: okay for mapped, slverr for anything else
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `CJD_RESP_OKAY;
    end else begin
      bvalid_q <= bvalid_nx;
      if (commit) bresp_q <= w_hit ? `CJD_RESP_OKAY : `CJD_RESP_SLVERR;
    end
  end

  // software-visible registers; status is read-only and ignores writes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 4; i++) ctrl_word_q[i] <= `CJD_RST_CW;
      jump_reg_q[0] <= `CJD_RST_JREG;
      jump_reg_q[1] <= `CJD_RST_JREG;
      core_sel_q    <= `CJD_RST_CORE_SEL;
    end else if (commit) begin
      unique case (aw_idx_q)
        `CJD_IDX_CW_A_B1: ctrl_word_q[0] <= merge16(ctrl_word_q[0], wdata_q, wstrb_q);
        `CJD_IDX_CW_B_B1: ctrl_word_q[1] <= merge16(ctrl_word_q[1], wdata_q, wstrb_q);
        `CJD_IDX_CW_A_B2: ctrl_word_q[2] <= merge16(ctrl_word_q[2], wdata_q, wstrb_q);
        `CJD_IDX_CW_B_B2: ctrl_word_q[3] <= merge16(ctrl_word_q[3], wdata_q, wstrb_q);
        `CJD_IDX_JREG0:   jump_reg_q[0]  <= merge16(jump_reg_q[0], wdata_q, wstrb_q);
        `CJD_IDX_JREG1:   jump_reg_q[1]  <= merge16(jump_reg_q[1], wdata_q, wstrb_q);
        `CJD_IDX_CORE_SEL: begin
          if (wstrb_q[0]) core_sel_q <= wdata_q[1:0];
        end
        default: begin
          // status and unmapped: nothing stored
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------------
  logic        ar_take;
  logic        rvalid_nx;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [9:0]  ar_idx;

  assign ar_take   = s_axi_arvalid && arready_q;
  assign rvalid_nx = ar_take || (rvalid_q && !s_axi_rready);
  assign ar_idx    = s_axi_araddr[11:2];

  // read mux; unused upper bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (ar_idx)
      `CJD_IDX_CW_A_B1:  rd_word[15:0] = ctrl_word_q[0];
      `CJD_IDX_CW_B_B1:  rd_word[15:0] = ctrl_word_q[1];
      `CJD_IDX_CW_A_B2:  rd_word[15:0] = ctrl_word_q[2];
      `CJD_IDX_CW_B_B2:  rd_word[15:0] = ctrl_word_q[3];
      `CJD_IDX_JREG0:    rd_word[15:0] = jump_reg_q[0];
      `CJD_IDX_JREG1:    rd_word[15:0] = jump_reg_q[1];
      `CJD_IDX_CORE_SEL: rd_word[1:0]  = core_sel_q;
      `CJD_IDX_STATUS: begin
        rd_word[ADDR_W-1:0]     = pc_q;
        rd_word[`CJD_TAKEN_BIT] = taken_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // data captured at the address handshake, held until rready
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `CJD_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_nx;
      rvalid_q  <= rvalid_nx;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? `CJD_RESP_OKAY : `CJD_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign program_counter_o = pc_q;
  assign jump_taken_o      = jump_taken_q;
  assign jump_seen_o       = jump_seen_q;
  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;

endmodule

//--- verification/cjd_top_checker.sv
`include "cjd_defs.svh"

module cjd_top_checker #(
  parameter int ADDR_W = 10
) (
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic              instr_valid_i,
  input wire logic [15:0]       instr_i,
  input wire logic [15:0]       alu_flags_i,
  input wire logic [ADDR_W-1:0] program_counter_o,
  input wire logic              jump_taken_o,
  input wire logic              jump_seen_o
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire far_alu = instr_i[15:9] == `CJD_JARF_HI && instr_i[3:0] == `CJD_JARF_LO;
  wire rel_alu = instr_i[15:9] == `CJD_JARR_HI;
  wire far_ctl = instr_i[15:10] == `CJD_JCRF_HI && instr_i[3:0] == `CJD_JCRF_LO;
  wire flag    = alu_flags_i[instr_i[8:5]];   // selected alu condition
  // offset sign-extended first, so the add wraps at the pc width
  wire [ADDR_W-1:0] rel_tgt = program_counter_o + ADDR_W'($signed(instr_i[4:0]));
  sequence rel_hit_s;
    instr_valid_i && rel_alu && flag;
  endsequence
  sequence alu_miss_s;
    instr_valid_i && (far_alu || rel_alu) && !flag;
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  rel_target_a: assert property (rel_hit_s |=> jump_taken_o &&
    program_counter_o == $past(rel_tgt)) else $error("relative target wrong");
  miss_step_a: assert property (alu_miss_s |=> !jump_taken_o &&
    program_counter_o == $past(program_counter_o) + 1'b1) else $error("miss did not step");
  far_taken_a: assert property (instr_valid_i && far_alu && flag
    |=> jump_taken_o && jump_seen_o) else $error("far alu jump not taken");
  rel_seen_a: assert property (instr_valid_i && rel_alu |=> jump_seen_o)
    else $error("relative jump not seen");
  ctl_seen_a: assert property (instr_valid_i && far_ctl |=> jump_seen_o)
    else $error("control jump not seen");
  ctl_pair_a: assert property (instr_valid_i && far_ctl |=> jump_taken_o ||
    program_counter_o == $past(program_counter_o) + 1'b1) else $error("control miss wrong");
  plain_step_a: assert property (instr_valid_i && !(far_alu || rel_alu || far_ctl)
    |=> !jump_seen_o && !jump_taken_o) else $error("plain word seen as jump");
  // an idle edge leaves the pc alone and raises no pulse one cycle later
  idle_hold_a: assert property (!instr_valid_i |=> !jump_seen_o && !jump_taken_o &&
    $stable(program_counter_o)) else $error("idle pulse or pc move");
endmodule

bind cjd_top cjd_top_checker #(.ADDR_W(ADDR_W)) u_cjd_top_checker (
  .clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .alu_flags_i(alu_flags_i), .program_counter_o(program_counter_o),
  .jump_taken_o(jump_taken_o), .jump_seen_o(jump_seen_o));

//--- verification/cjd_code_mem.sv
// code memory model: combinational read at the pc, loaded by the bench
module cjd_code_mem #(
  parameter int ADDR_W = 10
) (
  input  wire logic              clk_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] wa_i,
  input  wire logic [15:0]       wd_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic      [15:0]       rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_q [2**ADDR_W];   // unloaded words stay unknown on purpose
  // ---------------------------------------------------------------
  // load and fetch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[wa_i] <= wd_i;
    end
  end
  assign rd_o = mem_q[addr_i];
endmodule

//--- verification/cjd_top_tb_top.sv
`include "cjd_defs.svh"

module cjd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals and reference state
  // ---------------------------------------------------------------
  logic clk_i, reset_i, instr_valid, taken, seen, mem_we;
  logic [15:0] instr, alu_flags, mem_wd;
  logic [9:0] pc, mem_wa, pc_m;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lt_m;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, csel_m;
  logic [15:0] jreg_m [2];
  logic [15:0] cw_m [4];
  logic [9:0] cw_ix [4] = '{`CJD_IDX_CW_A_B1, `CJD_IDX_CW_B_B1, `CJD_IDX_CW_A_B2, `CJD_IDX_CW_B_B2};
  int err_count, comparisons;

  cjd_top u_cjd_top (.clk_i(clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid),
    .instr_i(instr), .alu_flags_i(alu_flags), .program_counter_o(pc), .jump_taken_o(taken),
    .jump_seen_o(seen), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  cjd_code_mem u_cjd_code_mem (.clk_i(clk_i), .we_i(mem_we), .wa_i(mem_wa), .wd_i(mem_wd),
    .addr_i(pc), .rd_o(instr));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // bench tasks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // each channel held until its own ready; the watchdog bounds every wait
  task automatic axw(input logic [9:0] ix, input logic [31:0] d, input logic [1:0] er);
    logic a, w;
    @(posedge clk_i);
    {a, w} = 2'b00;
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk_i);
      if (!a && s_axi_awready) begin a = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w && s_axi_wready) begin w = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge clk_i); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp(s_axi_bresp, er, "bresp");
  endtask
  task automatic axr(input logic [9:0] ix, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    cmp(s_axi_rdata, exp, "rdata");
    cmp(s_axi_rresp, er, "rresp");
  endtask
  // load the word at the current pc, execute it once, check the outcome
  task automatic step(input logic [15:0] w, input logic [15:0] fl);
    logic hit, jmp;
    logic [9:0] nx;
    @(posedge clk_i);
    mem_we <= 1'b1;
    mem_wa <= pc_m;
    mem_wd <= w;
    alu_flags <= fl;
    @(posedge clk_i);
    mem_we <= 1'b0;
    instr_valid <= 1'b1;
    @(posedge clk_i);
    instr_valid <= 1'b0;
    {jmp, hit} = 2'b10;
    nx = jreg_m[w[4]][9:0];
    if (w[15:9] == 7'h1D && w[3:0] == 4'h5) hit = fl[w[8:5]];
    else if (w[15:9] == 7'h12) begin
      hit = fl[w[8:5]];
      nx = pc_m + {{5{w[4]}}, w[4:0]};
    end else if (w[15:10] == 6'h0F && w[3:0] == 4'h4) hit = cw_m[csel_m][w[8:5]] == w[9];
    else jmp = 1'b0;
    if (!hit) nx = pc_m + 10'h001;
    if (jmp) lt_m = hit;
    pc_m = nx;
    #1;
    cmp(pc, pc_m, "pc"); // next pc
    cmp(taken, hit, "taken"); // condition
    cmp(seen, jmp, "seen"); // decode
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {reset_i, instr_valid, mem_we, alu_flags, mem_wa, mem_wd} = {3'b100, 42'h0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {56'h0, 4'hF};
    {err_count, comparisons, pc_m, csel_m, lt_m} = '0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      axr(cw_ix[i], 32'h0, `CJD_RESP_OKAY); // control words reset to zero
      cw_m[i] = 16'h5A3C ^ (16'h1357 << i);
      axw(cw_ix[i], {16'hFFFF, cw_m[i]}, `CJD_RESP_OKAY);
      axr(cw_ix[i], {16'h0, cw_m[i]}, `CJD_RESP_OKAY);
    end
    axr(`CJD_IDX_JREG0, 32'h0, `CJD_RESP_OKAY);
    axr(`CJD_IDX_CORE_SEL, 32'h0, `CJD_RESP_OKAY);
    axr(10'h000, 32'h0, `CJD_RESP_SLVERR);
    axw(10'h3FF, 32'hFFFF_FFFF, `CJD_RESP_SLVERR);
    jreg_m = '{16'h0123, 16'h03F0};
    for (int i = 0; i < 2; i++) axw(10'(`CJD_IDX_JREG0 + i), {16'h0, jreg_m[i]}, `CJD_RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      step({7'h1D, 4'(i), 1'(i), 4'h5}, 16'h0001 << i);
      step({7'h1D, 4'(i), 1'(i), 4'h5}, ~(16'h0001 << i)); // missed flag
    end
    jreg_m[0] = 16'h0002;
    axw(`CJD_IDX_JREG0, 32'h2, `CJD_RESP_OKAY);
    step(16'h3A05, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      step({7'h12, 4'(i), i[0] ? 5'h0F : 5'h10}, 16'h0001 << i); // wrap below zero and past the top
      step({7'h12, 4'(i), 5'h0F}, ~(16'h0001 << i));
    end
    for (int c = 0; c < 4; c++) begin
      csel_m = 2'(c);
      axw(`CJD_IDX_CORE_SEL, 32'(c), `CJD_RESP_OKAY);
      for (int i = 0; i < 32; i++) step({6'h0F, i[0], 4'(i >> 1), i[1], 4'h4}, 16'hFFFF);
    end
    step(16'h0000, 16'hFFFF);
    axr(`CJD_IDX_STATUS, {16'h0, lt_m, 5'h00, pc_m}, `CJD_RESP_OKAY);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule
